// ### logic/can_filter_irq_sleep_ctrl.sv
// What this block does
// - single mode matches 29 id bits plus flags
// - double mode: two 16-bit filters
// - quad mode: four filters on first byte
// - mask bit set excludes bit from compare
// - only a hit fills foreground, sets full
// - report lowest matching filter index
// - four vectors, eleven sources, masked, global gate
// - tx irq on empty; rx after frame end
// - bus activity during sleep sets wakeup flag
// - warning flags at counter 96
// - passive above 127, bus off above 255
// - third frame while both full: overrun, drop
// - flags clear by writing one
// - clear ignored while condition persists
// - error counters never written by software
// - configuration writes only under soft reset
// - transmit pin recessive in stop mode
// - sleep after idle, then acknowledge
// - wake on activity or request cleared
// - request clear ignored before acknowledge
// - keep running and interrupting in wait
// - optional low-pass filter on wakeup input
// - own frames stay in background buffer unless loop-back
`timescale 1ns/1ps
`include "can_filter_consts.svh"

module can_filter_irq_sleep_ctrl #(
  parameter int WAKE_CYCLES = `WAKE_FILTER_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // can pins
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  // protocol engine side
  input wire logic core_tx,
  input wire logic core_bus_idle,
  input wire logic rx_frame_valid,
  output logic rx_frame_ready,
  input wire logic [31:0] rx_frame_id,
  input wire logic [`DATA_W-1:0] rx_frame_data,
  input wire logic rx_frame_own,
  input wire logic [8:0] rx_error_count,
  input wire logic [8:0] tx_error_count,
  input wire logic [2:0] tx_empty_flag,
  // locked configuration
  input wire logic soft_reset_lock,
  input wire logic cfg_write,
  input wire logic [31:0] id_accept_pattern_in,
  input wire logic [31:0] id_mask_pattern_in,
  input wire logic [1:0] id_accept_control_in,
  input wire logic [7:0] bit_timing_zero_in,
  input wire logic [7:0] bit_timing_one_in,
  input wire logic [7:0] module_control_one_in,
  output logic [31:0] id_accept_pattern,
  output logic [31:0] id_mask_pattern,
  output logic [1:0] id_accept_control,
  output logic [7:0] bit_timing_zero,
  output logic [7:0] bit_timing_one,
  output logic [7:0] module_control_one,
  // flags and enables
  input wire logic flag_clear_write,
  input wire logic [7:0] flag_clear_mask,
  input wire logic [7:0] flag_enable,
  input wire logic [2:0] tx_empty_enable,
  input wire logic cpu_irq_mask,
  output logic [7:0] rx_flag_register,
  output logic [1:0] filter_hit_index,
  // foreground receive buffer
  output logic [31:0] rx_foreground_id,
  output logic [`DATA_W-1:0] rx_foreground_data,
  // interrupts
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_receive,
  output logic irq_transmit,
  // power modes
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic sleep_request_in,
  output logic sleep_request,
  output logic sleep_acknowledge,
  output logic module_clock_run,
  output logic cpu_wake
);

  // all state in one packed struct
  // outputs are plain flop bits
  can_filter_pkg::state_t cur; // registered state
  can_filter_pkg::state_t nxt; // next state

  // one compare shared by all modes
  // masked compare of one byte; a mask bit of one means don't care
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] pat,
                                      input logic [7:0] msk);
    byte_match = ((id ^ pat) & ~msk) == `ZERO8;
  endfunction : byte_match

  // working values of the comb logic
  logic [3:0] filt_hit; // per filter hit
  logic any_hit; // at least one filter hit
  logic [1:0] low_hit; // lowest hit index
  logic deliver; // frame goes toward the foreground
  logic fg_full; // foreground holds an unread frame
  logic rx_clear; // software releases the foreground
  logic [7:0] set_cond; // conditions that set flags
  logic [7:0] persist; // conditions that block a clear
  logic dominant; // filtered receive line is dominant
  logic wake_event; // accepted bus activity in sleep
  logic [7:0] fl; // working copy of flags

  // single: whole 32-bit word
  // double: two 16-bit filters
  // quad: four 8-bit filters
  // closed: nothing passes
  // id word as offered at frame end
  // unused hit bits stay zero
  // filter evaluation on the offered frame
  always_comb begin
    filt_hit = 4'h0;
    unique case (cur.accept_mode)
      `MODE_SINGLE: begin
        // whole 32-bit word: id bits plus rtr, ide and srr
        filt_hit[0] = byte_match(rx_frame_id[31:24], cur.pattern[31:24], cur.mask[31:24])
          && byte_match(rx_frame_id[23:16], cur.pattern[23:16], cur.mask[23:16])
          && byte_match(rx_frame_id[15:8], cur.pattern[15:8], cur.mask[15:8])
          && byte_match(rx_frame_id[7:0], cur.pattern[7:0], cur.mask[7:0]);
      end
      `MODE_DOUBLE: begin
        // first two id bytes against each half of the pattern
        filt_hit[0] = byte_match(rx_frame_id[31:24], cur.pattern[31:24], cur.mask[31:24])
          && byte_match(rx_frame_id[23:16], cur.pattern[23:16], cur.mask[23:16]);
        filt_hit[1] = byte_match(rx_frame_id[31:24], cur.pattern[15:8], cur.mask[15:8])
          && byte_match(rx_frame_id[23:16], cur.pattern[7:0], cur.mask[7:0]);
      end
      `MODE_QUAD: begin
        // first id byte against each pattern byte
        for (int k = 0; k < 4; k++) begin
          filt_hit[k] = byte_match(rx_frame_id[31:24], cur.pattern[31-8*k -: 8],
                                   cur.mask[31-8*k -: 8]);
        end
      end
      default: begin
        // closed: nothing is accepted
        filt_hit = 4'h0;
      end
    endcase
  end

  // fixed chain, cheaper than a tree
  // priority: lowest numbered filter wins
  always_comb begin
    any_hit = |filt_hit;
    low_hit = 2'h0;
    // first hit wins
    if (filt_hit[0]) begin
      low_hit = 2'h0;
    end else if (filt_hit[1]) begin
      low_hit = 2'h1;
    end else if (filt_hit[2]) begin
      low_hit = 2'h2;
    end else if (filt_hit[3]) begin
      low_hit = 2'h3;
    end
  end

  // the only builder of the next copy
  // next state
  always_comb begin
    nxt = cur;
    fl = cur.flags;
    fg_full = cur.flags[`FLAG_RX_FULL];

    // pin is asynchronous to clock
    // last two stages must agree
    // receive line: three stages, a change counts when the last two agree
    nxt.rx_sync = {cur.rx_sync[1:0], can_rx_pin};
    if (cur.rx_sync[1] == cur.rx_sync[2]) begin
      nxt.rx_level = cur.rx_sync[2];
    end
    dominant = !cur.rx_level;

    // on line writes drop silently
    // set soft reset to reprogram
    // locked configuration, only taken while soft reset is set
    if (cfg_write && soft_reset_lock) begin
      nxt.pattern = id_accept_pattern_in;
      nxt.mask = id_mask_pattern_in;
      nxt.accept_mode = id_accept_control_in;
      nxt.btr0 = bit_timing_zero_in;
      nxt.btr1 = bit_timing_one_in;
      nxt.mctl1 = module_control_one_in;
    end

    // error counters are only read here, there is no write path
    set_cond = 8'h00;
    set_cond[`FLAG_RX_WARN] = rx_error_count >= `WARN_LIMIT;
    set_cond[`FLAG_TX_WARN] = tx_error_count >= `WARN_LIMIT;
    set_cond[`FLAG_RX_PASSIVE] = rx_error_count > `PASSIVE_LIMIT;
    set_cond[`FLAG_TX_PASSIVE] = tx_error_count > `PASSIVE_LIMIT;
    set_cond[`FLAG_BUS_OFF] = tx_error_count > `BUS_OFF_LIMIT;
    persist = set_cond;

    // counter flags hold over limit
    // rx full clear always frees
    // zero mask bits leave flags
    // software clear: write one clears, zero leaves alone
    rx_clear = flag_clear_write && flag_clear_mask[`FLAG_RX_FULL] && fg_full;
    if (flag_clear_write) begin
      fl = fl & ~(flag_clear_mask & ~persist);
    end

    // rx full stays high across move up
    // a queued background frame moves up as soon as the foreground frees
    if (rx_clear && cur.bg_pending) begin
      nxt.fg_id = cur.bg_id;
      nxt.fg_data = cur.bg_data;
      nxt.hit_index = cur.bg_hit;
      nxt.bg_pending = 1'b0;
      fl[`FLAG_RX_FULL] = 1'b1;
    end

    // foreground if free, else background
    // both full: ready low, overrun
    // frame arrival at end of frame; own frames stay in the background unless loop-back is set
    deliver = any_hit && (!rx_frame_own || cur.mctl1[`MCTL1_LOOPBACK]);
    if (rx_frame_valid && cur.frame_ready) begin
      if (deliver && (!fg_full || rx_clear) && !cur.bg_pending) begin
        nxt.fg_id = rx_frame_id;
        nxt.fg_data = rx_frame_data;
        nxt.hit_index = low_hit;
        fl[`FLAG_RX_FULL] = 1'b1;
      end else if (deliver) begin
        nxt.bg_id = rx_frame_id; // wait behind the unread foreground
        nxt.bg_data = rx_frame_data;
        nxt.bg_hit = low_hit;
        nxt.bg_pending = 1'b1;
      end else if (!cur.bg_pending) begin
        nxt.bg_id = rx_frame_id;
        nxt.bg_data = rx_frame_data;
      end
    end else if (rx_frame_valid) begin
      // both buffers hold valid frames: drop the newcomer
      set_cond[`FLAG_OVERRUN] = 1'b1;
    end

    // run, then pending on request
    // asleep once the bus is idle
    // pending flags no wakeup
    // dropped request kept to ack
    // sleep handshake; a clear of the request before acknowledge is ignored
    wake_event = 1'b0;
    if (sleep_request_in) begin
      nxt.sleep_request = 1'b1;
    end else if (cur.slp_state == can_filter_pkg::st_asleep) begin
      nxt.sleep_request = 1'b0;
    end
    // saturates, cannot wrap
    // wakeup filter counts the line dominant for a least time
    if (cur.slp_state == can_filter_pkg::st_asleep && dominant) begin
      if (cur.wake_count != 8'(WAKE_CYCLES)) begin
        nxt.wake_count = cur.wake_count + 8'h01;
      end
    end else begin
      nxt.wake_count = `ZERO8;
    end
    if (cur.mctl1[`MCTL1_WAKE_FILTER]) begin
      wake_event = dominant && (cur.wake_count >= 8'(WAKE_CYCLES - 1));
    end else begin
      wake_event = dominant;
    end
    // sleep state step
    unique case (cur.slp_state)
      can_filter_pkg::st_run: begin
        if (cur.sleep_request) begin
          nxt.slp_state = can_filter_pkg::st_pending;
        end
      end
      can_filter_pkg::st_pending: begin
        // no wakeup can be flagged here, acknowledge is still low
        if (!cur.sleep_request) begin
          nxt.slp_state = can_filter_pkg::st_run;
        end else if (core_bus_idle) begin
          nxt.slp_state = can_filter_pkg::st_asleep;
        end
      end
      can_filter_pkg::st_asleep: begin
        if (wake_event) begin
          set_cond[`FLAG_WAKEUP] = 1'b1;
          nxt.slp_state = can_filter_pkg::st_run;
          nxt.sleep_request = 1'b0;
        end else if (!sleep_request_in) begin
          nxt.slp_state = can_filter_pkg::st_run;
        end
      end
      default: begin
        nxt.slp_state = can_filter_pkg::st_run;
      end
    endcase
    // clock stops only while asleep
    nxt.clock_run = nxt.slp_state != can_filter_pkg::st_asleep;

    // ready from next copy
    // set wins over a clear in the same cycle
    nxt.flags = fl | set_cond;
    nxt.frame_ready = !(nxt.flags[`FLAG_RX_FULL] && nxt.bg_pending);

    // stop and sleep silence tx
    // transmit pin recessive in stop and in sleep
    nxt.tx_pin = (cpu_stop || nxt.slp_state == can_filter_pkg::st_asleep) ? 1'b1
      : core_tx;

    // irqs follow next flags
    // so they fall with a clear
    // interrupts: local enables then global mask; wait mode does not gate them
    nxt.irq_wakeup = !cpu_irq_mask && nxt.flags[`FLAG_WAKEUP]
      && flag_enable[`FLAG_WAKEUP];
    nxt.irq_error = !cpu_irq_mask && |(nxt.flags[`FLAG_OVERRUN:`FLAG_RX_WARN]
      & flag_enable[`FLAG_OVERRUN:`FLAG_RX_WARN]);
    nxt.irq_receive = !cpu_irq_mask && nxt.flags[`FLAG_RX_FULL]
      && flag_enable[`FLAG_RX_FULL];
    nxt.irq_transmit = !cpu_irq_mask && |(tx_empty_flag & tx_empty_enable);
    nxt.cpu_wake = cpu_wait && (nxt.irq_error || nxt.irq_receive
      || nxt.irq_transmit);
  end

  // line and pin reset to recessive
  // so no false edge after release
  // single register for the whole state
  always_ff @(posedge clock or negedge rstn) begin
    // async reset, constants only
    if (!rstn) begin
      cur <= '0;
      cur.rx_sync <= 3'h7;
      cur.rx_level <= 1'b1;
      // mask resets to all don't care
      cur.mask <= `MASK_RESET;
      cur.slp_state <= can_filter_pkg::st_run;
      cur.tx_pin <= 1'b1;
      cur.frame_ready <= 1'b1;
      cur.clock_run <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // outputs straight from the state register
  assign can_tx_pin = cur.tx_pin;
  assign rx_frame_ready = cur.frame_ready;
  assign id_accept_pattern = cur.pattern;
  assign id_mask_pattern = cur.mask;
  assign id_accept_control = cur.accept_mode;
  assign bit_timing_zero = cur.btr0;
  assign bit_timing_one = cur.btr1;
  assign module_control_one = cur.mctl1;
  assign rx_flag_register = cur.flags;
  assign filter_hit_index = cur.hit_index;
  assign rx_foreground_id = cur.fg_id;
  assign rx_foreground_data = cur.fg_data;
  assign irq_wakeup = cur.irq_wakeup;
  assign irq_error = cur.irq_error;
  assign irq_receive = cur.irq_receive;
  assign irq_transmit = cur.irq_transmit;
  assign sleep_request = cur.sleep_request;
  // ack is the upper state bit, set only asleep
  assign sleep_acknowledge = cur.slp_state[1];
  assign module_clock_run = cur.clock_run;
  assign cpu_wake = cur.cpu_wake;

endmodule : can_filter_irq_sleep_ctrl

// ### logic/can_filter_consts.svh
`ifndef CAN_FILTER_CONSTS_SVH
`define CAN_FILTER_CONSTS_SVH

// acceptance filter modes
`define MODE_SINGLE 2'h0
`define MODE_DOUBLE 2'h1
`define MODE_QUAD 2'h2
`define MODE_CLOSED 2'h3

// flag register bit positions
`define FLAG_WAKEUP 0
`define FLAG_RX_WARN 1
`define FLAG_TX_WARN 2
`define FLAG_RX_PASSIVE 3
`define FLAG_TX_PASSIVE 4
`define FLAG_BUS_OFF 5
`define FLAG_OVERRUN 6
`define FLAG_RX_FULL 7

// module control one field positions
`define MCTL1_LOOPBACK 0
`define MCTL1_WAKE_FILTER 2

// error counter limits
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h07f
`define BUS_OFF_LIMIT 9'h0ff

// reset values
`define MASK_RESET 32'hffffffff
`define ZERO8 8'h00

// wakeup low-pass filter: least dominant time on the receive line
`define CLOCK_PERIOD_NS 20
`define WAKE_FILTER_NS 2000
`define WAKE_FILTER_CYCLES ((`WAKE_FILTER_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// frame payload width
`define DATA_W 64

`endif

// ### logic/can_filter_pkg.sv
`include "can_filter_consts.svh"

package can_filter_pkg;

  // sleep handshake states, gray coded along run -> pending -> asleep
  typedef enum logic [1:0] {
    st_run = 2'h0,
    st_pending = 2'h1,
    st_asleep = 2'h3
  } sleep_state_t;

  // whole state of the block
  typedef struct packed {
    logic [2:0] rx_sync;
    logic rx_level;
    logic [31:0] pattern;
    logic [31:0] mask;
    logic [1:0] accept_mode;
    logic [7:0] btr0;
    logic [7:0] btr1;
    logic [7:0] mctl1;
    logic [31:0] bg_id;
    logic [`DATA_W-1:0] bg_data;
    logic bg_pending;
    logic [1:0] bg_hit;
    logic [31:0] fg_id;
    logic [`DATA_W-1:0] fg_data;
    logic [1:0] hit_index;
    logic [7:0] flags;
    sleep_state_t slp_state;
    logic sleep_request;
    logic [7:0] wake_count;
    logic tx_pin;
    logic irq_wakeup;
    logic irq_error;
    logic irq_receive;
    logic irq_transmit;
    logic cpu_wake;
    logic frame_ready;
    logic clock_run;
  } state_t;

endpackage : can_filter_pkg

// ### test/can_bus_model.sv
`timescale 1ns/1ps
// far side: other nodes on the bus, wired-and with our own transmit pin
module can_bus_model (
  // clock
  input wire logic clock,
  // bus pins
  input wire logic can_tx_pin,
  output logic can_rx_pin
);
  logic other_n = 1'h1; // other nodes release to recessive, the bus pull level
  // dominant wins on the wire, so our own bits are seen as well
  assign can_rx_pin = can_tx_pin & other_n;
  // another node holds the bus dominant for n cycles
  task automatic drive_dom(input int n);
    @(negedge clock);
    other_n = 1'h0;
    repeat (n) @(negedge clock);
    other_n = 1'h1;
  endtask : drive_dom
endmodule : can_bus_model

// ### test/can_filter_irq_sleep_ctrl_sva.sv
`timescale 1ns/1ps
module can_filter_irq_sleep_ctrl_sva #(
  parameter int WAKE_CYCLES = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // pins and power modes
  input wire logic can_tx_pin,
  input wire logic cpu_stop,
  input wire logic sleep_request,
  input wire logic sleep_acknowledge,
  // frames and counters
  input wire logic rx_frame_valid,
  input wire logic rx_frame_ready,
  input wire logic [8:0] rx_error_count,
  input wire logic [8:0] tx_error_count,
  // flags and interrupts
  input wire logic [7:0] rx_flag_register,
  input wire logic [7:0] flag_enable,
  input wire logic [2:0] tx_empty_flag,
  input wire logic [2:0] tx_empty_enable,
  input wire logic cpu_irq_mask,
  input wire logic irq_wakeup,
  input wire logic irq_error,
  input wire logic irq_receive,
  input wire logic irq_transmit
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // request rises while the block is still awake
  sequence s_req_rise;
    $rose(sleep_request) && !sleep_acknowledge;
  endsequence
  sequence s_no_ack;
    !sleep_acknowledge;
  endsequence
  property p_ack_late;
    s_req_rise |=> s_no_ack;
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("sleep ack too early");
  property p_stop_tx;
    cpu_stop |=> can_tx_pin;
  endproperty
  a_stop_tx: assert property (p_stop_tx) else $error("tx pin not recessive");
  property p_rx_irq;
    !cpu_irq_mask && flag_enable[7] |=> irq_receive == rx_flag_register[7];
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive irq missing");
  property p_mask;
    cpu_irq_mask |=> !(irq_wakeup || irq_error || irq_receive || irq_transmit);
  endproperty
  a_mask: assert property (p_mask) else $error("irq despite global mask");
  property p_tx_irq;
    (|(tx_empty_flag & tx_empty_enable)) && !cpu_irq_mask |=> irq_transmit;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit irq missing");
  property p_err_irq;
    !cpu_irq_mask |=> irq_error == (|(rx_flag_register[6:1] & $past(flag_enable[6:1])));
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq missing");
  property p_warn;
    rx_error_count >= 9'h060 |=> rx_flag_register[1];
  endproperty
  a_warn: assert property (p_warn) else $error("rx warning flag missing");
  property p_passive;
    tx_error_count > 9'h07f |=> rx_flag_register[4];
  endproperty
  a_passive: assert property (p_passive) else $error("tx passive flag missing");
  property p_bus_off;
    tx_error_count > 9'h0ff |=> rx_flag_register[5];
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus off flag missing");
  property p_overrun;
    rx_frame_valid && !rx_frame_ready |-> ##[1:2] rx_flag_register[6];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag missing");
endmodule : can_filter_irq_sleep_ctrl_sva

bind can_filter_irq_sleep_ctrl can_filter_irq_sleep_ctrl_sva #(
  .WAKE_CYCLES(WAKE_CYCLES)
) checker_inst (.clock, .rstn, .can_tx_pin, .cpu_stop, .sleep_request,
  .sleep_acknowledge, .rx_frame_valid, .rx_frame_ready, .rx_error_count, .tx_error_count,
  .rx_flag_register, .flag_enable, .tx_empty_flag, .tx_empty_enable, .cpu_irq_mask,
  .irq_wakeup, .irq_error, .irq_receive, .irq_transmit);

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // design inputs
  logic clock, rstn, core_tx, core_bus_idle, rx_frame_valid, rx_frame_own, cfg_write;
  logic soft_reset_lock, flag_clear_write, cpu_irq_mask, cpu_wait, cpu_stop;
  logic sleep_request_in;
  logic [31:0] rx_frame_id, id_accept_pattern_in, id_mask_pattern_in;
  logic [63:0] rx_frame_data;
  logic [8:0] rx_error_count, tx_error_count;
  logic [2:0] tx_empty_flag, tx_empty_enable;
  logic [1:0] id_accept_control_in;
  logic [7:0] bit_timing_zero_in, bit_timing_one_in, module_control_one_in;
  logic [7:0] flag_clear_mask, flag_enable;
  // design outputs
  wire logic can_rx_pin, can_tx_pin, rx_frame_ready, irq_wakeup, irq_error, irq_receive;
  wire logic irq_transmit, sleep_request, sleep_acknowledge, module_clock_run, cpu_wake;
  wire logic [31:0] id_accept_pattern, id_mask_pattern, rx_foreground_id;
  wire logic [63:0] rx_foreground_data;
  wire logic [1:0] id_accept_control, filter_hit_index;
  wire logic [7:0] bit_timing_zero, bit_timing_one, module_control_one, rx_flag_register;
  int errors = 0, tests_run = 0, cycles = 0;
  // short wake filter keeps the sleep tests quick
  can_filter_irq_sleep_ctrl #(.WAKE_CYCLES(4)) can_filter_irq_sleep_ctrl_inst (.clock,
    .rstn, .can_rx_pin, .can_tx_pin, .core_tx, .core_bus_idle, .rx_frame_valid,
    .rx_frame_ready, .rx_frame_id, .rx_frame_data, .rx_frame_own, .rx_error_count,
    .tx_error_count, .tx_empty_flag, .soft_reset_lock, .cfg_write, .id_accept_pattern_in,
    .id_mask_pattern_in, .id_accept_control_in, .bit_timing_zero_in, .bit_timing_one_in,
    .module_control_one_in, .id_accept_pattern, .id_mask_pattern, .id_accept_control,
    .bit_timing_zero, .bit_timing_one, .module_control_one, .flag_clear_write,
    .flag_clear_mask, .flag_enable, .tx_empty_enable, .cpu_irq_mask, .rx_flag_register,
    .filter_hit_index, .rx_foreground_id, .rx_foreground_data, .irq_wakeup, .irq_error,
    .irq_receive, .irq_transmit, .cpu_wait, .cpu_stop, .sleep_request_in, .sleep_request,
    .sleep_acknowledge, .module_clock_run, .cpu_wake);
  can_bus_model can_bus_model_inst (.clock, .can_tx_pin, .can_rx_pin);
  // 50 MHz clock
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_n
  // one configuration write of all locked values
  task automatic cfg(input logic [31:0] pat, msk, input logic [1:0] mode, input logic [7:0] mc);
    @(negedge clock);
    id_accept_pattern_in = pat;
    id_mask_pattern_in = msk;
    id_accept_control_in = mode;
    module_control_one_in = mc;
    bit_timing_zero_in = pat[7:0];
    bit_timing_one_in = msk[7:0];
    cfg_write = 1'h1;
    @(negedge clock);
    cfg_write = 1'h0;
  endtask : cfg
  // one frame offered at end of frame, id and data as one unit
  task automatic frame(input logic [31:0] id, input logic own);
    @(negedge clock);
    rx_frame_id = id;
    rx_frame_data = {id, ~id};
    rx_frame_own = own;
    rx_frame_valid = 1'h1;
    @(negedge clock);
    rx_frame_valid = 1'h0;
  endtask : frame
  task automatic clr(input logic [7:0] m);
    @(negedge clock);
    flag_clear_mask = m;
    flag_clear_write = 1'h1;
    @(negedge clock);
    flag_clear_write = 1'h0;
  endtask : clr
  // program a filter, offer one frame, check acceptance, release the buffer
  task automatic filt(input logic [1:0] mode, input logic [31:0] pat, msk, id,
    input logic hit, input logic [1:0] idx);
    cfg(pat, msk, mode, 8'h00);
    frame(id, 1'h0);
    chk("rx_full", hit, rx_flag_register[7]);
    wait_n(1);
    chk("irq_receive", hit, irq_receive);
    if (hit) begin
      chk("hit_index", idx, filter_hit_index);
      chk("fg_id", id, rx_foreground_id);
      chk("fg_data", ~id, rx_foreground_data[31:0]);
    end
    clr(8'h80);
  endtask : filt
  initial begin
    {rstn, core_tx, core_bus_idle, rx_frame_valid, rx_frame_own, cfg_write} = 6'h18;
    {soft_reset_lock, flag_clear_write, cpu_irq_mask, cpu_wait, cpu_stop} = 5'h10;
    {sleep_request_in, rx_frame_id, rx_frame_data, rx_error_count, tx_error_count} = '0;
    {tx_empty_flag, tx_empty_enable, id_accept_control_in, flag_clear_mask} = '0;
    {id_accept_pattern_in, id_mask_pattern_in, module_control_one_in} = '0;
    {bit_timing_zero_in, bit_timing_one_in} = '0;
    flag_enable = 8'hff;
    wait_n(2);
    rstn = 1'h1;
    // configuration lock
    cfg(32'h12345678, 32'h0, 2'h0, 8'h00);
    soft_reset_lock = 1'h0;
    cfg(32'h0, 32'hffffffff, 2'h3, 8'h04);
    chk("pattern", 32'h12345678, id_accept_pattern);
    chk("mask", 32'h0, id_mask_pattern);
    chk("cfg", 32'h78, {id_accept_control, module_control_one, bit_timing_one, bit_timing_zero});
    soft_reset_lock = 1'h1;
    // every filter mode
    filt(2'h0, 32'h12345678, 32'h0, 32'h12345678, 1'h1, 2'h0);
    filt(2'h0, 32'h12345678, 32'h0, 32'h12345679, 1'h0, 2'h0);
    filt(2'h0, 32'h12345678, 32'h000000ff, 32'h123456a5, 1'h1, 2'h0);
    filt(2'h1, 32'haaaa5555, 32'h0, 32'h5555f00f, 1'h1, 2'h1);
    filt(2'h1, 32'haaaa5555, 32'h0, 32'haaab0000, 1'h0, 2'h0);
    filt(2'h1, 32'haaaaaaaa, 32'h0, 32'haaaa0000, 1'h1, 2'h0);
    filt(2'h2, 32'h11223344, 32'h0, 32'h33ffffff, 1'h1, 2'h2);
    filt(2'h2, 32'h11223344, 32'h0, 32'h44000000, 1'h1, 2'h3);
    filt(2'h2, 32'h11112222, 32'h0, 32'h11000000, 1'h1, 2'h0);
    filt(2'h3, 32'h0, 32'hffffffff, 32'h0, 1'h0, 2'h0);
    // both buffers full, third frame refused
    cfg(32'h0, 32'hffffffff, 2'h0, 8'h00);
    frame(32'h1, 1'h0);
    frame(32'h2, 1'h0);
    chk("ready", 1'h0, rx_frame_ready);
    frame(32'h3, 1'h0);
    wait_n(2);
    chk("overrun", 1'h1, rx_flag_register[6]);
    chk("irq_error", 1'h1, irq_error);
    clr(8'h80);
    chk("fg_id", 32'h2, rx_foreground_id);
    clr(8'hc0);
    chk("flags", 8'h00, rx_flag_register);
    // own frames only reach the foreground in loop-back
    frame(32'h5, 1'h1);
    chk("own", 1'h0, rx_flag_register[7]);
    cfg(32'h0, 32'hffffffff, 2'h0, 8'h01);
    frame(32'h6, 1'h1);
    chk("loopback", 1'h1, rx_flag_register[7]);
    clr(8'h80);
    // error counter limits at their boundaries
    {rx_error_count, tx_error_count} = {9'h05f, 9'h05f};
    wait_n(2);
    chk("below", 8'h00, rx_flag_register);
    {rx_error_count, tx_error_count} = {9'h060, 9'h07f};
    wait_n(2);
    chk("warn", 8'h06, rx_flag_register);
    {rx_error_count, tx_error_count} = {9'h080, 9'h080};
    wait_n(2);
    chk("passive", 8'h1e, rx_flag_register);
    clr(8'hff);
    chk("held", 8'h1e, rx_flag_register);
    cpu_irq_mask = 1'h1;
    wait_n(2);
    chk("masked", 1'h0, irq_error);
    cpu_irq_mask = 1'h0;
    tx_error_count = 9'h100;
    wait_n(2);
    chk("bus_off", 8'h3e, rx_flag_register);
    {rx_error_count, tx_error_count} = '0;
    clr(8'hff);
    chk("cleared", 8'h00, rx_flag_register);
    // transmit irq, local enable and wait mode
    tx_empty_flag = 3'h4;
    wait_n(2);
    chk("tx_off", 1'h0, irq_transmit);
    tx_empty_enable = 3'h4;
    cpu_wait = 1'h1;
    wait_n(3);
    chk("tx_irq", 1'h1, irq_transmit);
    chk("wake_cpu", 1'h1, cpu_wake);
    {tx_empty_flag, cpu_wait} = '0;
    // stop mode
    core_tx = 1'h0;
    wait_n(2);
    chk("tx_pin", 1'h0, can_tx_pin);
    cpu_stop = 1'h1;
    wait_n(2);
    chk("tx_stop", 1'h1, can_tx_pin);
    {cpu_stop, core_tx, core_bus_idle, sleep_request_in} = 4'h5;
    // sleep while the bus is busy, early clear ignored
    wait_n(4);
    chk("ack_busy", 1'h0, sleep_acknowledge);
    sleep_request_in = 1'h0;
    wait_n(2);
    chk("req_held", 1'h1, sleep_request);
    {core_bus_idle, sleep_request_in} = 2'h3;
    wait_n(4);
    chk("ack", 1'h1, sleep_acknowledge);
    chk("clk_run", 1'h0, module_clock_run);
    core_tx = 1'h0;
    wait_n(2);
    chk("tx_sleep", 1'h1, can_tx_pin);
    {core_tx, sleep_request_in} = 2'h2;
    wait_n(3);
    chk("woke", 1'h0, sleep_acknowledge);
    // filtered wakeup: a glitch is ignored, a long dominant wakes
    cfg(32'h0, 32'hffffffff, 2'h0, 8'h04);
    sleep_request_in = 1'h1;
    wait_n(4);
    can_bus_model_inst.drive_dom(2);
    wait_n(6);
    chk("glitch", 1'h1, sleep_acknowledge);
    can_bus_model_inst.drive_dom(8);
    wait_n(6);
    chk("wake_flag", 1'h1, rx_flag_register[0]);
    chk("irq_wake", 1'h1, irq_wakeup);
    sleep_request_in = 1'h0;
    test_done();
  end
endmodule : tb_top
